/* File: rtl/jps_pkg.sv */
/*
  Shared constants and carrier types for the test-port pin sharing logic.
  Assumes a single 100 MHz system clock and an active-low async reset.
*/
package jps_pkg;

  // ==========================================================================
  // Lane layout
  // ==========================================================================
  localparam int unsigned LANES   = 3;
  localparam int unsigned IDX_TDI = 0;
  localparam int unsigned IDX_TCK = 1;
  localparam int unsigned IDX_TMS = 2;

  // ==========================================================================
  // Monitor sizing and reset values
  // ==========================================================================
  localparam int unsigned CNT_W         = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic SYNC_RST_SEL         = 1'b1;
  localparam logic SYNC_RST_TCK         = 1'b0;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic test_sig;
    logic board_sig;
  } jps_lane_in_t;

  typedef struct packed {
    logic mux_pin;
    logic prog_drv_o;
    logic prog_drv_oe_n;
    logic brd_drv_o;
    logic brd_drv_oe_n;
  } jps_lane_out_t;

  typedef struct packed {
    logic data;
    logic oe_n;
  } jps_drive_t;

  typedef enum logic [1:0] {
    JPS_IDLE,
    JPS_ENTER,
    JPS_PROG,
    JPS_LEAVE
  } jps_mode_t;

endpackage

/* File: rtl/jps_lane.sv */
/*
  One shared input lane: selects between a test-port input and a board
  input for a single device pin, as a selector and as a driver pair.
  Assumes the select line is already at a clean logic level.
*/
`timescale 1ns/1ps
module jps_lane
  import jps_pkg::*;
(
  input  wire logic          program_select_n,
  input  wire jps_lane_in_t  lane_in,
  output jps_lane_out_t      lane_out
);

  // ==========================================================================
  // Selection
  // ==========================================================================
  // No storage here: the pin follows the select line at once.
  always_comb begin
    lane_out.mux_pin = program_select_n ? lane_in.board_sig
                                        : lane_in.test_sig;
    // Enables are opposite polarities of one line, so one drives at a time.
    lane_out.prog_drv_o    = lane_in.test_sig;
    lane_out.prog_drv_oe_n = program_select_n;
    lane_out.brd_drv_o     = lane_in.board_sig;
    lane_out.brd_drv_oe_n  = ~program_select_n;
  end

endmodule // jps_lane

/* File: rtl/jps_pin_mux.sv */
/*
  Test-port pin sharing logic: steers the shared test-data-in, test-clock
  and test-mode-select pins and the test-data-out pin between programming
  and normal operation, plus a sampled monitor of the programming session.
  Assumes program_select_n and test_clk come straight from the cable.
*/
// Summary of operation
// - A two-input selector routes test input or board signal to the pin.
// - Alternatively two drivers with opposite enables; exactly one drives.
// - Test data in, clock and mode select pins are inputs while programming.
// - Test data out drives while programming; otherwise user I/O.
// - While programming, test signals never disturb the board's nets.
// - In normal mode, board signals never reach or feel test signals.
`timescale 1ns/1ps
module jps_pin_mux
  import jps_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                program_select_n,
  input  wire logic                test_port_enable_request,
  input  wire logic                test_data_in,
  input  wire logic                test_clk,
  input  wire logic                test_mode_sel,
  input  wire logic [LANES-1:0]    board_in,
  input  wire logic [LANES-1:0]    core_pin_o,
  input  wire logic [LANES-1:0]    core_pin_oe_n,
  input  wire logic                dev_test_data_out,
  input  wire logic                core_tdo_pin_o,
  input  wire logic                core_tdo_pin_oe_n,
  input  wire logic                tdo_pin_i,
  output logic [LANES-1:0]         shared_pin_in,
  output jps_lane_out_t [LANES-1:0] lane_drive,
  output jps_drive_t [LANES-1:0]   shared_pin_drive,
  output jps_drive_t               tdo_pin_drive,
  output jps_drive_t               cable_tdo_drive,
  output jps_drive_t               board_tdo_drive,
  output logic                     prog_active_q,
  output logic                     session_start_q,
  output logic                     session_end_q,
  output logic                     enable_mismatch_q,
  output logic [CNT_W-1:0]         tck_rise_count_q
);

  // ==========================================================================
  // Shared input lanes
  // ==========================================================================
  jps_lane_in_t [LANES-1:0] lane_in;
  logic [LANES-1:0]         test_vec;
  logic                     prog_mode;

  // The data path deliberately bypasses the synchronisers below; adding a
  // clock here would delay the test clock and break the cable's timing.
  assign prog_mode = ~program_select_n;

  assign test_vec[IDX_TDI] = test_data_in;
  assign test_vec[IDX_TCK] = test_clk;
  assign test_vec[IDX_TMS] = test_mode_sel;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign lane_in[g].test_sig  = test_vec[g];
    assign lane_in[g].board_sig = board_in[g];

    jps_lane u_lane (
      .program_select_n (program_select_n),
      .lane_in          (lane_in[g]),
      .lane_out         (lane_drive[g])
    );

    assign shared_pin_in[g] = lane_drive[g].mux_pin;
  end

  // ==========================================================================
  // Device-side drivers of the three input-only test pins
  // ==========================================================================
  // The core's own drive is cut off while programming, so the pin only
  // receives; the user design must not rely on these pins otherwise.
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      shared_pin_drive[i].data = core_pin_o[i];
      shared_pin_drive[i].oe_n = prog_mode | core_pin_oe_n[i];
    end
  end

  // ==========================================================================
  // Test data out pin
  // ==========================================================================
  always_comb begin
    if (prog_mode) begin
      tdo_pin_drive.data = dev_test_data_out;
      tdo_pin_drive.oe_n = 1'b0;
    end else begin
      tdo_pin_drive.data = core_tdo_pin_o;
      tdo_pin_drive.oe_n = core_tdo_pin_oe_n;
    end
  end

  // The pin's value goes to the cable only while programming and to the
  // board only outside it, so neither side ever sees the other.
  always_comb begin
    cable_tdo_drive.data = tdo_pin_i;
    cable_tdo_drive.oe_n = program_select_n;
    board_tdo_drive.data = tdo_pin_i;
    board_tdo_drive.oe_n = prog_mode;
  end

  // ==========================================================================
  // Synchronisers for the monitor
  // ==========================================================================
  logic sel_meta_q;
  logic sel_sync_q;
  logic tck_meta_q;
  logic tck_sync_q;
  logic tck_prev_q;
  logic req_meta_q;
  logic req_sync_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_meta_q <= SYNC_RST_SEL;
      sel_sync_q <= SYNC_RST_SEL;
    end else begin
      sel_meta_q <= program_select_n;
      sel_sync_q <= sel_meta_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_meta_q <= SYNC_RST_TCK;
      tck_sync_q <= SYNC_RST_TCK;
      tck_prev_q <= SYNC_RST_TCK;
    end else begin
      tck_meta_q <= test_clk;
      tck_sync_q <= tck_meta_q;
      tck_prev_q <= tck_sync_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= test_port_enable_request;
      req_sync_q <= req_meta_q;
    end
  end

  logic tck_rise;
  assign tck_rise = tck_sync_q & ~tck_prev_q;

  // ==========================================================================
  // Session tracking
  // ==========================================================================
  jps_mode_t mode_q;
  jps_mode_t mode_d;

  // One decode serves the activity flag and the edge counter, so the two
  // can never disagree about what counts as inside a session.
  function automatic logic in_session(input jps_mode_t m);
    return (m == JPS_ENTER) || (m == JPS_PROG);
  endfunction

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      JPS_IDLE:  if (!sel_sync_q) mode_d = JPS_ENTER;
      JPS_ENTER: mode_d = sel_sync_q ? JPS_LEAVE : JPS_PROG;
      JPS_PROG:  if (sel_sync_q) mode_d = JPS_LEAVE;
      JPS_LEAVE: mode_d = sel_sync_q ? JPS_IDLE : JPS_ENTER;
      default:   mode_d = JPS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= JPS_IDLE;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_active_q   <= 1'b0;
      session_start_q <= 1'b0;
      session_end_q   <= 1'b0;
    end else begin
      prog_active_q   <= in_session(mode_d);
      session_start_q <= (mode_d == JPS_ENTER);
      session_end_q   <= (mode_d == JPS_LEAVE);
    end
  end

  // A cable that asks for the test port must also pull the select line low.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_mismatch_q <= 1'b0;
    end else begin
      enable_mismatch_q <= req_sync_q & sel_sync_q;
    end
  end

  // ==========================================================================
  // Test clock edge counter
  // ==========================================================================
  // Counts saturate so a long session never wraps back to a small value.
  // Edges faster than half the system clock rate are not resolved.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_rise_count_q <= CNT_ZERO;
    end else if (mode_d == JPS_ENTER) begin
      tck_rise_count_q <= tck_rise ? CNT_ONE : CNT_ZERO;
    end else if (in_session(mode_d) && tck_rise
                 && tck_rise_count_q != CNT_MAX) begin
      tck_rise_count_q <= tck_rise_count_q + CNT_ONE;
    end
  end

endmodule // jps_pin_mux

/* File: tb/jps_chk.sv */
/* Checker for the pin sharing block: steering, isolation and monitor.
   Assumes it is bound to jps_pin_mux and clocked by sys_clk. */
`timescale 1ns/1ps
module jps_chk
  import jps_pkg::*;
(
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire logic                     program_select_n,
  input wire logic                     test_port_enable_request,
  input wire logic                     test_data_in,
  input wire logic                     test_clk,
  input wire logic                     test_mode_sel,
  input wire logic [LANES-1:0]         board_in,
  input wire logic [LANES-1:0]         core_pin_oe_n,
  input wire logic                     dev_test_data_out,
  input wire logic [LANES-1:0]         shared_pin_in,
  input wire jps_lane_out_t [LANES-1:0] lane_drive,
  input wire jps_drive_t [LANES-1:0]   shared_pin_drive,
  input wire jps_drive_t               tdo_pin_drive,
  input wire jps_drive_t               cable_tdo_drive,
  input wire jps_drive_t               board_tdo_drive,
  input wire logic                     prog_active_q,
  input wire logic                     session_start_q,
  input wire logic                     session_end_q,
  input wire logic                     enable_mismatch_q
);
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Five low samples leave room for the two-stage synchroniser.
  sequence s_enter;
    $fell(program_select_n) ##1 !program_select_n [*4];
  endsequence
  sequence s_leave;
    $rose(program_select_n) ##1 program_select_n [*4];
  endsequence
  // Three samples after an edge the synchroniser has handed it on.
  sequence s_fall_seen;
    $fell(program_select_n) ##1 !program_select_n [*2];
  endsequence
  sequence s_rise_seen;
    $rose(program_select_n) ##1 program_select_n [*2];
  endsequence
  a_mux_route: assert property (
    shared_pin_in == (program_select_n ? board_in :
      {test_mode_sel, test_clk, test_data_in})
  ) else $error("shared pin input routed wrongly");
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    a_drv_pair: assert property (
      lane_drive[i].prog_drv_oe_n == program_select_n &&
      lane_drive[i].brd_drv_oe_n != program_select_n
    ) else $error("driver pair enables not opposite");
    a_core_cut: assert property (
      shared_pin_drive[i].oe_n == (!program_select_n | core_pin_oe_n[i])
    ) else $error("core drive not cut while programming");
  end
  a_tdo_prog: assert property (
    !program_select_n |-> tdo_pin_drive == {dev_test_data_out, 1'b0}
  ) else $error("test data out not driven while programming");
  a_tdo_iso: assert property (
    cable_tdo_drive.oe_n == program_select_n &&
    board_tdo_drive.oe_n != program_select_n
  ) else $error("test data out reaches the wrong side");
  a_enter_active: assert property (
    s_enter |-> prog_active_q
  ) else $error("session not seen after select fell");
  a_leave_idle: assert property (
    s_leave |-> !prog_active_q
  ) else $error("session still active after select rose");
  a_start_pulse: assert property (
    session_start_q |-> prog_active_q ##1 !session_start_q
  ) else $error("start pulse wrong");
  a_end_pulse: assert property (
    session_end_q |-> !prog_active_q ##1 !session_end_q
  ) else $error("end pulse wrong");
  a_start_fires: assert property (
    s_fall_seen |=> session_start_q
  ) else $error("start pulse missing after select fell");
  a_end_fires: assert property (
    s_rise_seen |=> session_end_q
  ) else $error("end pulse missing after select rose");
  a_req_mismatch: assert property (
    (test_port_enable_request && program_select_n) [*5] |-> enable_mismatch_q
  ) else $error("enable request with select high not flagged");
endmodule // jps_chk

bind jps_pin_mux jps_chk chk_u (
  .sys_clk, .rst_n, .program_select_n, .test_port_enable_request,
  .test_data_in, .test_clk, .test_mode_sel, .board_in, .core_pin_oe_n,
  .dev_test_data_out, .shared_pin_in, .lane_drive, .shared_pin_drive,
  .tdo_pin_drive, .cable_tdo_drive, .board_tdo_drive, .prog_active_q,
  .session_start_q, .session_end_q, .enable_mismatch_q
);

/* File: tb/jps_cable.sv */
/* Cable model: select, enable request and the three test inputs.
   Assumes the bench calls its tasks; lines change on falling edges. */
`timescale 1ns/1ps
module jps_cable (
  input  wire logic sys_clk,
  output logic      program_select_n,
  output logic      test_port_enable_request,
  output logic      test_data_in,
  output logic      test_clk,
  output logic      test_mode_sel
);
  // ==========================================================
  // Cable actions
  // ==========================================================
  initial begin
    program_select_n = 1'b1;
    test_port_enable_request = 1'b0;
    {test_mode_sel, test_clk, test_data_in} = 3'h0;
  end
  task automatic set_pins(input logic sel, input logic [2:0] t);
    @(negedge sys_clk);
    program_select_n = sel;
    test_port_enable_request = ~sel;
    {test_mode_sel, test_clk, test_data_in} = t;
  endtask
  // Link clock runs only inside a frame, 160 ns period, idle low.
  task automatic frame(input int n);
    set_pins(1'b0, 3'h0);
    repeat (n) begin
      repeat (8) @(negedge sys_clk);
      test_clk = 1'b1;
      repeat (8) @(negedge sys_clk);
      test_clk = 1'b0;
      test_data_in = ~test_data_in;
      test_mode_sel = test_data_in;
    end
    repeat (8) @(negedge sys_clk);
    // Released data lines show the inverse, never a stale level.
    set_pins(1'b1, {~test_mode_sel, 1'b0, ~test_data_in});
  endtask
  // Deliberate fault: request raised while select stays high.
  task automatic bad_request(input logic v);
    @(negedge sys_clk);
    test_port_enable_request = v;
  endtask
endmodule // jps_cable

/* File: tb/tb_top.sv */
/* Self-checking bench for jps_pin_mux driven by the cable model.
   Assumes a 100 MHz sys_clk; inputs change on falling edges. */
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb_top
  import jps_pkg::*;
;
  // ==========================================================
  // Stimulus and checks
  // ==========================================================
  typedef struct packed {
    logic       sel;
    logic [2:0] t;
    logic [2:0] b;
    logic [2:0] coe;
    logic       dto;
    logic [2:0] si;
    logic [2:0] oe;
    jps_drive_t tdo;
  } jps_row_t;
  logic                      sys_clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic [LANES-1:0]          board_in = 3'h0;
  logic [LANES-1:0]          core_pin_oe_n = 3'h7;
  logic                      dto = 1'b0;
  logic                      sel_n, req, tdi, tck, tms, act, mm;
  logic [LANES-1:0]          spi;
  jps_lane_out_t [LANES-1:0] lanes;
  jps_drive_t [LANES-1:0]    spd;
  jps_drive_t                tdo_d, cab_d, brd_d;
  logic [CNT_W-1:0]          cnt;
  int                        n_fail = 0;
  int                        cmp_count = 0;
  jps_row_t                  r;
  jps_lane_out_t             exp_lane;
  jps_row_t rows [4] = '{'{1'b1, 3'h5, 3'h2, 3'h4, 1'b1, 3'h2, 3'h4, 2'h0},
    '{1'b0, 3'h5, 3'h2, 3'h0, 1'b1, 3'h5, 3'h7, 2'h2},
    '{1'b1, 3'h3, 3'h5, 3'h3, 1'b0, 3'h5, 3'h3, 2'h3},
    '{1'b0, 3'h2, 3'h5, 3'h7, 1'b0, 3'h2, 3'h7, 2'h0}};
  always #5 sys_clk = ~sys_clk;
  jps_cable cable_u (.sys_clk(sys_clk), .program_select_n(sel_n),
    .test_port_enable_request(req), .test_data_in(tdi), .test_clk(tck),
    .test_mode_sel(tms));
  jps_pin_mux dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .program_select_n(sel_n), .test_port_enable_request(req),
    .test_data_in(tdi), .test_clk(tck), .test_mode_sel(tms),
    .board_in(board_in), .core_pin_o(board_in ^ 3'h5),
    .core_pin_oe_n(core_pin_oe_n), .dev_test_data_out(dto),
    .core_tdo_pin_o(~dto), .core_tdo_pin_oe_n(core_pin_oe_n[0]),
    .tdo_pin_i(tdi ^ board_in[0]), .shared_pin_in(spi), .lane_drive(lanes),
    .shared_pin_drive(spd), .tdo_pin_drive(tdo_d), .cable_tdo_drive(cab_d),
    .board_tdo_drive(brd_d), .prog_active_q(act), .session_start_q(),
    .session_end_q(), .enable_mismatch_q(mm), .tck_rise_count_q(cnt));
  task automatic close_out();
    $display("counts: %0d compared, %0d failed", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bounded wait on a monitor flag; running out ends the run.
  task automatic await(input logic v, input int w);
    logic s;
    s = 1'bx;
    for (int k = 0; k < 40 && s !== v; k++) begin
      @(negedge sys_clk);
      s = (w == 0) ? act : mm;
    end
    `CHK(s, v)
    if (s !== v) close_out();
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      cable_u.set_pins(r.sel, r.t);
      board_in = r.b;
      core_pin_oe_n = r.coe;
      dto = r.dto;
      #1;
      `CHK(spi, r.si)
      `CHK({spd[2].oe_n, spd[1].oe_n, spd[0].oe_n}, r.oe)
      `CHK({spd[2].data, spd[1].data, spd[0].data}, r.b ^ 3'h5)
      `CHK(tdo_d, r.tdo)
      `CHK({cab_d.oe_n, brd_d.oe_n}, {r.sel, ~r.sel})
      `CHK({cab_d.data, brd_d.data}, {2{r.t[0] ^ r.b[0]}})
      for (int j = 0; j < LANES; j++) begin
        exp_lane = '{r.si[j], r.t[j], r.sel, r.b[j], ~r.sel};
        `CHK(lanes[j], exp_lane)
      end
    end
    $display("test rows done");
    cable_u.frame(5);
    await(1'b0, 0);
    `CHK(cnt, 16'h0005)
    $display("test frame done");
    cable_u.bad_request(1'b1);
    await(1'b1, 1);
    repeat (4) @(negedge sys_clk);
    cable_u.bad_request(1'b0);
    await(1'b0, 1);
    $display("test fault done");
    cable_u.set_pins(1'b0, 3'h7);
    await(1'b1, 0);
    rst_n = 1'b0;
    #1;
    `CHK({spi, act, cnt}, {3'h7, 1'b0, 16'h0000})
    @(negedge sys_clk);
    rst_n = 1'b1;
    await(1'b1, 0);
    cable_u.set_pins(1'b1, 3'h0);
    await(1'b0, 0);
    $display("test reset done");
    close_out();
  end
endmodule // tb_top
